// >>> tb/flash_ctrl_assertions.sv
`timescale 1ns/1ps
module flash_ctrl_assertions
  import flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic stop_req,
  input wire logic array_start,
  input wire logic [7:0] array_cmd,
  input wire logic array_abort,
  input wire logic array_done
);
  logic run_q;
  logic run_d;
  logic rs;
  // Completed status register read as seen from the pins only
  assign rs = avs_read && !avs_waitrequest && avs_address == OFS_STATUS;
  always_comb
  begin
    run_d = run_q;
    if (array_done || array_abort)
      run_d = 1'b0;
    if (array_start)
      run_d = 1'b1;
  end
  always_ff @(posedge sys_clk)
    run_q <= srst ? 1'b0 : run_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait over one cycle");
  property p_zero_bits;
    rs |-> avs_readdata[31:8] == 24'h0 && avs_readdata[3] == 1'b0 && avs_readdata[1:0] == 2'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused status bits set");
  property p_full_busy;
    rs && !avs_readdata[BIT_CBEF] |-> !avs_readdata[BIT_CCF];
  endproperty
  a_full_busy: assert property (p_full_busy) else $error("complete while buffer full");
  property p_cc_idle;
    rs && avs_readdata[BIT_CCF] |-> !run_q;
  endproperty
  a_cc_idle: assert property (p_cc_idle) else $error("complete while array busy");
  property p_blank_src;
    rs && avs_readdata[BIT_BLANK] |-> array_cmd == CMD_BLANK;
  endproperty
  a_blank_src: assert property (p_blank_src) else $error("blank flag without blank check");
  property p_stop_abort;
    $rose(stop_req) && run_q && !array_done |-> ##[1:3] array_abort;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
  property p_abort_run;
    array_abort |-> run_q;
  endproperty
  a_abort_run: assert property (p_abort_run) else $error("abort while idle");
  property p_start_idle;
    array_start |-> !run_q;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while busy");
  property p_start_once;
    array_start |=> !array_start;
  endproperty
  a_start_once: assert property (p_start_once) else $error("start pulse too long");
endmodule // flash_ctrl_assertions
bind flash_ctrl flash_ctrl_assertions chk (.sys_clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .stop_req, .array_start, .array_cmd, .array_abort, .array_done);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import flash_pkg::*;
  logic sys_clk, srst, avs_read, avs_write, stop_req, array_done, array_blank;
  logic avs_waitrequest, array_start, array_abort, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [7:0] array_cmd, array_data;
  logic [15:0] array_addr;
  int fail_count = 0;
  int compares = 0;
  flash_ctrl DUT (.sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .stop_req, .array_start, .array_cmd,
    .array_addr, .array_data, .array_abort, .array_done, .array_blank, .irq);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task end_sim;
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task ck(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  // Waitrequest and read data are taken at the same rising edge; release follows it by NBA
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      end_sim;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    ck(q, e);
  endtask
  task launch(input logic [7:0] c, input logic [15:0] ad);
    bus(1'b1, OFS_ADDR_DATA, {8'h00, 8'h5a, ad});
    bus(1'b1, OFS_CMD, {24'h0, c});
    bus(1'b1, OFS_STATUS, 32'h80);
  endtask
  task wstart(input logic [7:0] c);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (array_start !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      end_sim;
    end
    ck({24'h0, array_cmd}, {24'h0, c});
    ck({24'h0, array_data}, 32'h5a);
  endtask
  task fin(input logic b);
    @(posedge sys_clk);
    array_done <= 1'b1;
    array_blank <= b;
    @(posedge sys_clk);
    array_done <= 1'b0;
    array_blank <= 1'b0;
  endtask
  task t_ro;
    rc(OFS_STATUS, 32'hc0);
    bus(1'b1, OFS_STATUS, 32'h4f);
    rc(OFS_STATUS, 32'hc0);
    rc(5'h02, 32'h0);
    rc(OFS_IRQ_CLEAR, 32'h0);
  endtask
  task t_err;
    launch(CMD_PROG, 16'h0000);
    rc(OFS_STATUS, 32'hd0);
    bus(1'b1, OFS_STATUS, 32'h0);
    rc(OFS_STATUS, 32'hd0);
    bus(1'b1, OFS_STATUS, 32'h10);
    rc(OFS_STATUS, 32'hc0);
    bus(1'b1, OFS_CMD, {24'h0, CMD_PROG});
    rc(OFS_STATUS, 32'hd0);
    bus(1'b1, OFS_STATUS, 32'h10);
    bus(1'b1, OFS_STATUS, 32'h80);
    rc(OFS_STATUS, 32'hd0);
    bus(1'b1, OFS_STATUS, 32'h10);
  endtask
  task t_cmds;
    logic [7:0] cs [6];
    cs = '{CMD_BLANK, CMD_PROG, CMD_BURST, CMD_SECT_ERASE, CMD_MASS_ERASE, CMD_BLANK};
    bus(1'b1, OFS_DIV, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      launch(cs[i], 16'h0100);
      // The start pulse lasts one cycle, so it is caught before the status read
      wstart(cs[i]);
      rc(OFS_STATUS, (cs[i] == CMD_BURST) ? 32'h80 : 32'h0);
      fin(i == 0);
      // Complete rises one edge after the buffer reopens on a non-burst finish
      @(posedge sys_clk);
      rc(OFS_STATUS, (i == 0) ? 32'hc4 : 32'hc0);
    end
  endtask
  task t_burst;
    launch(CMD_BURST, 16'h0000);
    wstart(CMD_BURST);
    launch(CMD_BURST, 16'h0002);
    rc(OFS_STATUS, 32'h0);
    bus(1'b1, OFS_STATUS, 32'h80);
    rc(OFS_STATUS, 32'h0);
    fin(1'b0);
    wstart(CMD_BURST);
    ck({16'h0, array_addr}, 32'h2);
    rc(OFS_STATUS, 32'h80);
    fin(1'b0);
    rc(OFS_STATUS, 32'hc0);
  endtask
  task t_prot;
    bus(1'b1, OFS_PROT, 32'h81);
    launch(CMD_PROG, 16'h0400);
    rc(OFS_STATUS, 32'he0);
    bus(1'b1, OFS_STATUS, 32'h0);
    rc(OFS_STATUS, 32'he0);
    bus(1'b1, OFS_STATUS, 32'h20);
    rc(OFS_STATUS, 32'hc0);
    bus(1'b1, OFS_PROT, 32'h0);
  endtask
  task t_stop;
    int n;
    launch(CMD_SECT_ERASE, 16'h0000);
    wstart(CMD_SECT_ERASE);
    @(posedge sys_clk);
    stop_req <= 1'b1;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (array_abort !== 1'b1 && n < 5);
    if (array_abort !== 1'b1)
    begin
      fail_count++;
      end_sim;
    end
    ck({31'h0, array_abort}, 32'h1);
    @(posedge sys_clk);
    stop_req <= 1'b0;
    rc(OFS_STATUS, 32'hd0);
    bus(1'b1, OFS_STATUS, 32'h10);
  endtask
  task t_irq;
    bus(1'b1, OFS_IRQ_CLEAR, 32'hf);
    rc(OFS_IRQ_STATUS, 32'h0);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h4);
    bus(1'b1, OFS_STATUS, 32'h80);
    rc(OFS_IRQ_STATUS, 32'h4);
    ck({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
    rc(OFS_IRQ_ENABLE, 32'h0);
    ck({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h4);
    rc(OFS_IRQ_STATUS, 32'h4);
    ck({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h4);
    rc(OFS_IRQ_STATUS, 32'h0);
    ck({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_STATUS, 32'h10);
  endtask
  initial
  begin
    srst = 1'b1;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    stop_req = 1'b0;
    array_done = 1'b0;
    array_blank = 1'b0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_ro;
    t_err;
    t_cmds;
    t_burst;
    t_prot;
    t_stop;
    t_irq;
    end_sim;
  end
endmodule // tb_top

// >>> verilog/exec_if.sv
`timescale 1ns/1ps
interface exec_if;
  logic start;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [7:0] data;
  logic abort;
  logic busy;
  logic done;
  logic blank_ok;
  modport ctrl (output start, cmd, addr, data, abort, input busy, done, blank_ok);
  modport eng (input start, cmd, addr, data, abort, output busy, done, blank_ok);
endinterface

// >>> verilog/flash_cmd_engine.sv
`timescale 1ns/1ps
module flash_cmd_engine
  import flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  exec_if.eng ex,
  output logic array_start,
  output logic [7:0] array_cmd,
  output logic [15:0] array_addr,
  output logic [7:0] array_data,
  output logic array_abort,
  input wire logic array_done,
  input wire logic array_blank
);
  eng_state_t state_q, state_d;
  logic [7:0] cmd_q, cmd_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic start_q, start_d;
  logic abort_q, abort_d;
  logic done_q, done_d;
  logic blank_q, blank_d;

  always_comb
  begin
    state_d = state_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    data_d = data_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    done_d = 1'b0;
    blank_d = blank_q;
    case (state_q)
      ENG_IDLE:
      begin
        if (ex.start)
        begin
          cmd_d = ex.cmd;
          addr_d = ex.addr;
          data_d = ex.data;
          start_d = 1'b1;
          state_d = ENG_RUN;
        end
      end
      ENG_RUN:
      begin
        // Abort wins over a late array completion so an aborted command never reports a blank result
        if (ex.abort)
        begin
          abort_d = 1'b1;
          done_d = 1'b1;
          blank_d = 1'b0;
          state_d = ENG_IDLE;
        end
        else if (array_done)
        begin
          done_d = 1'b1;
          blank_d = (cmd_q == CMD_BLANK) && array_blank;
          state_d = ENG_IDLE;
        end
      end
      default:
      begin
        state_d = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q <= ENG_IDLE;
      cmd_q <= RST_CMD;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      done_q <= 1'b0;
      blank_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      data_q <= data_d;
      start_q <= start_d;
      abort_q <= abort_d;
      done_q <= done_d;
      blank_q <= blank_d;
    end
  end

  assign ex.busy = (state_q != ENG_IDLE);
  assign ex.done = done_q;
  assign ex.blank_ok = blank_q;
  assign array_start = start_q;
  assign array_cmd = cmd_q;
  assign array_addr = addr_q;
  assign array_data = data_q;
  assign array_abort = abort_q;
endmodule // flash_cmd_engine

// >>> verilog/flash_ctrl.sv
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// Operation
// (RULE1) Writing one to bit 7 launches, clearing it
// (RULE2) Burst handover to array empties the buffer
// (RULE3) Bit 7 zero: buffer full, launches refused
// (RULE4) Bit 6 set when buffer empty, engine idle
// (RULE5) Bit 6 cleared when a command launches
// (RULE6) Software writes to bit 6 ignored
// (RULE7) Protected target sets bit 5, command dropped
// (RULE8) Bit 5 cleared only by writing one
// (RULE9) Broken sequence sets bit 4, command dropped
// (RULE10) Program or erase before divider write errors
// (RULE11) Stop during a command sets bit 4
// (RULE12) Bit 4 write one clears, zero keeps
// (RULE13) Blank check all erased sets bit 2
// (RULE14) Bit 2 cleared on valid command launch
// (RULE15) Bit 2 valid only once bit 6 set
// (RULE16) Software writes to bit 2 ignored
// (RULE17) Bits 3, 1, 0 read zero
module flash_ctrl
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stop_req,
  output logic array_start,
  output logic [7:0] array_cmd,
  output logic [15:0] array_addr,
  output logic [7:0] array_data,
  output logic array_abort,
  input wire logic array_done,
  input wire logic array_blank,
  output logic irq
);
  import flash_pkg::*;

  exec_if ex ();

  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic cbef_q, cbef_d;
  logic ccf_q, ccf_d;
  logic pviol_q, pviol_d;
  logic accerr_q, accerr_d;
  logic blank_q, blank_d;
  logic [7:0] div_q, div_d;
  logic div_written_q, div_written_d;
  logic [7:0] prot_q, prot_d;
  seq_state_t seq_q, seq_d;
  logic [7:0] cmd_q, cmd_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdat_q, wdat_d;
  logic pend_q, pend_d;
  logic [7:0] pend_cmd_q, pend_cmd_d;
  logic [15:0] pend_addr_q, pend_addr_d;
  logic [7:0] pend_data_q, pend_data_d;
  logic stop_q, stop_d;
  logic abort_q, abort_d;

  logic wr_ok;
  logic launch_req;
  logic is_pe;
  logic is_prot;
  logic acc_fail;
  logic prot_fail;
  logic accept;
  logic seq_err;
  logic stop_abort;
  logic handover;
  logic cmd_valid;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [7:0] status_byte;

  // Each access is answered on its second edge; the first edge only captures read data
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;

  assign status_byte = {cbef_q, ccf_q, pviol_q, accerr_q, 1'b0, blank_q, 2'b00}; // RULE17

  always_comb
  begin
    wr_ok = avs_write && ack_q && avs_byteenable[0];
    launch_req = wr_ok && (avs_address == OFS_STATUS) && avs_writedata[BIT_CBEF] && cbef_q; // RULE3
    is_pe = (cmd_q != CMD_BLANK);
    if (cmd_q == CMD_MASS_ERASE)
    begin
      is_prot = prot_q[BIT_PROT_EN];
    end
    else
    begin
      is_prot = is_pe && prot_q[BIT_PROT_EN] && (addr_q[15:9] >= prot_q[6:0]);
    end
    // Only a burst command may be buffered while the engine is still busy
    acc_fail = (seq_q != SEQ_CMD)
      || (is_pe && !div_written_q)
      || (ex.busy && (cmd_q != CMD_BURST)); // RULE9 RULE10
    prot_fail = !acc_fail && is_prot; // RULE7
    accept = launch_req && !acc_fail && !prot_fail;
    cmd_valid = (avs_writedata[7:0] == CMD_BLANK)
      || (avs_writedata[7:0] == CMD_PROG)
      || (avs_writedata[7:0] == CMD_BURST)
      || (avs_writedata[7:0] == CMD_SECT_ERASE)
      || (avs_writedata[7:0] == CMD_MASS_ERASE);
    stop_abort = stop_req && !stop_q && (ex.busy || pend_q); // RULE11
    handover = pend_q && !ex.busy && !stop_abort;
  end

  always_comb
  begin
    ack_d = (avs_read || avs_write) && !ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q)
    begin
      case (avs_address)
        OFS_STATUS: rdata_d = {24'h000000, status_byte};
        OFS_CMD: rdata_d = {24'h000000, cmd_q};
        OFS_DIV: rdata_d = {24'h000000, div_q};
        OFS_ADDR_DATA: rdata_d = {8'h00, wdat_q, addr_q};
        OFS_PROT: rdata_d = {24'h000000, prot_q};
        OFS_IRQ_STATUS: rdata_d = {28'h0000000, irq_status};
        OFS_IRQ_ENABLE: rdata_d = {28'h0000000, irq_enable};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_comb
  begin
    seq_d = seq_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    div_d = div_q;
    div_written_d = div_written_q;
    prot_d = prot_q;
    seq_err = 1'b0;
    if (wr_ok)
    begin
      case (avs_address)
        OFS_ADDR_DATA:
        begin
          if ((seq_q == SEQ_IDLE) && cbef_q)
          begin
            addr_d = avs_writedata[15:0];
            wdat_d = avs_writedata[23:16];
            seq_d = SEQ_ADDR;
          end
          else
          begin
            seq_err = 1'b1; // RULE9
            seq_d = SEQ_IDLE;
          end
        end
        OFS_CMD:
        begin
          if ((seq_q == SEQ_ADDR) && cbef_q && cmd_valid)
          begin
            cmd_d = avs_writedata[7:0];
            seq_d = SEQ_CMD;
          end
          else
          begin
            seq_err = 1'b1; // RULE9
            seq_d = SEQ_IDLE;
          end
        end
        OFS_DIV:
        begin
          div_d = avs_writedata[7:0];
          div_written_d = 1'b1; // RULE10
        end
        OFS_PROT:
        begin
          prot_d = avs_writedata[7:0];
        end
        default:
        begin
          seq_d = seq_q;
        end
      endcase
    end
    if (launch_req)
    begin
      seq_d = SEQ_IDLE;
    end
  end

  always_comb
  begin
    pend_d = pend_q;
    pend_cmd_d = pend_cmd_q;
    pend_addr_d = pend_addr_q;
    pend_data_d = pend_data_q;
    cbef_d = cbef_q;
    stop_d = stop_req;
    abort_d = stop_abort && ex.busy;
    if (accept)
    begin
      pend_d = 1'b1;
      pend_cmd_d = cmd_q;
      pend_addr_d = addr_q;
      pend_data_d = wdat_q;
      cbef_d = 1'b0; // RULE1
    end
    else if (stop_abort)
    begin
      pend_d = 1'b0;
      cbef_d = 1'b1;
    end
    else if (handover)
    begin
      pend_d = 1'b0;
      // Non-burst commands keep the buffer closed until they finish or a stop aborts them
      if (pend_cmd_q == CMD_BURST)
      begin
        cbef_d = 1'b1; // RULE2
      end
    end
    else if (ex.done && !pend_q)
    begin
      cbef_d = 1'b1;
    end
  end

  always_comb
  begin
    // Hardware owns bits 6 and 2; the write data never reaches them
    ccf_d = accept ? 1'b0 : (cbef_q && !ex.busy && !pend_q); // RULE4 RULE5 RULE6
    pviol_d = pviol_q;
    if (wr_ok && (avs_address == OFS_STATUS) && avs_writedata[BIT_PVIOL])
    begin
      pviol_d = 1'b0; // RULE8
    end
    if (launch_req && prot_fail)
    begin
      pviol_d = 1'b1; // RULE7
    end
    accerr_d = accerr_q;
    if (wr_ok && (avs_address == OFS_STATUS) && avs_writedata[BIT_ACCERR])
    begin
      accerr_d = 1'b0; // RULE12
    end
    if ((launch_req && acc_fail) || seq_err || stop_abort)
    begin
      accerr_d = 1'b1; // RULE9 RULE10 RULE11
    end
    blank_d = blank_q;
    if (accept)
    begin
      blank_d = 1'b0; // RULE14
    end
    if (ex.done && ex.blank_ok)
    begin
      blank_d = 1'b1; // RULE13 RULE15 RULE16
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      cbef_q <= RST_CBEF;
      ccf_q <= RST_CCF;
      pviol_q <= 1'b0;
      accerr_q <= 1'b0;
      blank_q <= 1'b0;
      div_q <= RST_DIV;
      div_written_q <= 1'b0;
      prot_q <= RST_PROT;
      seq_q <= SEQ_IDLE;
      cmd_q <= RST_CMD;
      addr_q <= 16'h0000;
      wdat_q <= 8'h00;
      pend_q <= 1'b0;
      pend_cmd_q <= RST_CMD;
      pend_addr_q <= 16'h0000;
      pend_data_q <= 8'h00;
      stop_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      cbef_q <= cbef_d;
      ccf_q <= ccf_d;
      pviol_q <= pviol_d;
      accerr_q <= accerr_d;
      blank_q <= blank_d;
      div_q <= div_d;
      div_written_q <= div_written_d;
      prot_q <= prot_d;
      seq_q <= seq_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      pend_q <= pend_d;
      pend_cmd_q <= pend_cmd_d;
      pend_addr_q <= pend_addr_d;
      pend_data_q <= pend_data_d;
      stop_q <= stop_d;
      abort_q <= abort_d;
    end
  end

  assign ex.start = handover;
  assign ex.cmd = pend_cmd_q;
  assign ex.addr = pend_addr_q;
  assign ex.data = pend_data_q;
  assign ex.abort = abort_q;

  always_comb
  begin
    irq_events = '0;
    irq_events[IRQ_CCF] = ccf_d && !ccf_q;
    irq_events[IRQ_PVIOL] = pviol_d && !pviol_q;
    irq_events[IRQ_ACCERR] = accerr_d && !accerr_q;
    irq_events[IRQ_BLANK] = blank_d && !blank_q;
  end

  flash_cmd_engine u_engine (
    .sys_clk(sys_clk),
    .srst(srst),
    .ex(ex.eng),
    .array_start(array_start),
    .array_cmd(array_cmd),
    .array_addr(array_addr),
    .array_data(array_data),
    .array_abort(array_abort),
    .array_done(array_done),
    .array_blank(array_blank)
  );

  flash_irq u_irq (
    .sys_clk(sys_clk),
    .srst(srst),
    .events(irq_events),
    .enable_we(wr_ok && (avs_address == OFS_IRQ_ENABLE)),
    .clear_we(wr_ok && (avs_address == OFS_IRQ_CLEAR)),
    .wdata(avs_writedata[IRQ_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );
endmodule // flash_ctrl

// >>> verilog/flash_irq.sv
`timescale 1ns/1ps
module flash_irq
  import flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [IRQ_W-1:0] events,
  input wire logic enable_we,
  input wire logic clear_we,
  input wire logic [IRQ_W-1:0] wdata,
  output logic [IRQ_W-1:0] status,
  output logic [IRQ_W-1:0] enable,
  output logic irq
);
  logic [IRQ_W-1:0] status_q, status_d;
  logic [IRQ_W-1:0] enable_q, enable_d;
  logic irq_q, irq_d;

  always_comb
  begin
    // New events are ORed in after the clear so a coincident event survives
    status_d = (status_q & ~(clear_we ? wdata : {IRQ_W{1'b0}})) | events;
    enable_d = enable_we ? wdata : enable_q;
    irq_d = |(status_d & enable_d);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      status_q <= '0;
      enable_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q <= irq_d;
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq = irq_q;
endmodule // flash_irq

// >>> verilog/flash_pkg.sv
package flash_pkg;
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_CMD = 5'h04;
  localparam logic [4:0] OFS_DIV = 5'h08;
  localparam logic [4:0] OFS_ADDR_DATA = 5'h0c;
  localparam logic [4:0] OFS_PROT = 5'h10;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h14;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h1c;
  localparam int BIT_CBEF = 7;
  localparam int BIT_CCF = 6;
  localparam int BIT_PVIOL = 5;
  localparam int BIT_ACCERR = 4;
  localparam int BIT_BLANK = 2;
  localparam int BIT_PROT_EN = 7;
  localparam logic RST_CBEF = 1'b1;
  localparam logic RST_CCF = 1'b1;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_PROT = 8'h00;
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [7:0] CMD_BLANK = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_BURST = 8'h03;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h04;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h05;
  localparam int IRQ_W = 4;
  localparam int IRQ_CCF = 0;
  localparam int IRQ_PVIOL = 1;
  localparam int IRQ_ACCERR = 2;
  localparam int IRQ_BLANK = 3;
  typedef enum {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} seq_state_t;
  typedef enum {ENG_IDLE, ENG_RUN} eng_state_t;
endpackage
